// ==== hw/trtr_receiver.sv ====
// Trail trace receiver: identifier capture, comparison, status, interrupt and Avalon-MM registers
`timescale 1ns/100ps

module trtr_receiver #(
    parameter logic [3:0] UNSTABLE_LIMIT = trtr_pkg::UNSTABLE_RUN,
    parameter logic [2:0] IDLE_LIMIT     = trtr_pkg::IDLE_RUN
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic  [9:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic  [3:0] avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        trace_bit,
    input  wire logic        trace_bit_valid,
    input  wire logic        trace_byte_start,
    output logic             irq
);
    import trtr_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    trtr_bus_state_t bus_state, next_bus_state;
    logic [31:0]  next_readdata;
    logic         next_waitrequest;
    logic [3:0]   control, next_control;
    logic [3:0]   expected_index, next_expected_index;
    logic [3:0]   received_index, next_received_index;
    logic [3:0]   irq_enable, next_irq_enable;
    logic         global_irq_enable, next_global_irq_enable;
    logic [127:0] exp_id, next_exp_id;
    logic [3:0]   latch_clear;
    logic         commit;
    logic [127:0] cap_id, next_cap_id;
    logic [127:0] cur_id, next_cur_id;
    logic [127:0] rx_id, next_rx_id;
    logic [3:0]   byte_pos, next_byte_pos;
    logic [3:0]   pos_wr;
    logic [127:0] assembled;
    logic [3:0]   unstable_cnt, next_unstable_cnt;
    logic [2:0]   idle_cnt, next_idle_cnt;
    logic         mismatch_status, next_mismatch_status;
    logic         unstable_status, next_unstable_status;
    logic         idle_status, next_idle_status;
    logic         id_done;
    logic         id_change;
    logic         cmp_active;
    logic [3:0]   latched, next_latched;
    logic         next_irq;
    logic [7:0]   rx_byte;
    logic         rx_byte_first;
    logic         rx_byte_valid;

    // Register decode, shared by the read mux and the write path
    function automatic logic reg_sel(input logic [9:0] addr, input logic [7:0] idx);
        reg_sel = (addr[9:2] == idx);
    endfunction : reg_sel

    // ------------------------------------------------------------------
    // Bit deserialiser
    // ------------------------------------------------------------------
    trtr_bit_deser u_deser (
        .ref_clk               (ref_clk),
        .srst                  (srst),
        .trace_bit             (trace_bit),
        .trace_bit_valid       (trace_bit_valid),
        .trace_byte_start      (trace_byte_start),
        .rx_invert_enable      (control[CTL_INVERT_BIT]),
        .rx_bit_reorder_enable (control[CTL_REORDER_BIT]),
        .byte_data             (rx_byte),
        .byte_first_bit        (rx_byte_first),
        .byte_valid            (rx_byte_valid)
    );

    // ------------------------------------------------------------------
    // Avalon-MM slave and software registers
    // ------------------------------------------------------------------
    // Read data is sampled one cycle ahead; side effects land only on the acknowledge edge
    always_comb begin
        commit                 = (avs_read || avs_write) && (bus_state == TRTR_BUS_ACK);
        next_bus_state         = TRTR_BUS_WAIT;
        next_readdata          = avs_readdata;
        next_control           = control;
        next_expected_index    = expected_index;
        next_received_index    = received_index;
        next_irq_enable        = irq_enable;
        next_global_irq_enable = global_irq_enable;
        next_exp_id            = exp_id;
        latch_clear            = 4'h0;
        if (bus_state == TRTR_BUS_WAIT && (avs_read || avs_write)) begin
            next_bus_state = TRTR_BUS_ACK;
            next_readdata  = 32'h0000_0000;   // Unmapped reads give zero
            if (avs_read) begin
                if (reg_sel(avs_address, REG_CONTROL_IDX))
                    next_readdata[3:0] = control;
                if (reg_sel(avs_address, REG_INDEX_IDX)) begin
                    next_readdata[IDX_EXP_LSB +: 4] = expected_index;
                    next_readdata[IDX_RX_LSB +: 4]  = received_index;
                end
                if (reg_sel(avs_address, REG_STATUS_IDX))
                    next_readdata[2:0] = {mismatch_status, unstable_status, idle_status};
                if (reg_sel(avs_address, REG_LATCHED_IDX))
                    next_readdata[3:0] = latched;
                if (reg_sel(avs_address, REG_IRQ_EN_IDX)) begin
                    next_readdata[3:0]            = irq_enable;
                    next_readdata[IRQ_GLOBAL_BIT] = global_irq_enable;
                end
                if (reg_sel(avs_address, REG_RX_ID_IDX))
                    next_readdata[7:0] = rx_id[{received_index, 3'b000} +: 8];
                if (reg_sel(avs_address, REG_EXP_ID_IDX))
                    next_readdata[7:0] = exp_id[{expected_index, 3'b000} +: 8];
            end
        end
        if (commit && avs_write) begin
            if (reg_sel(avs_address, REG_CONTROL_IDX) && avs_byteenable[0])
                next_control = avs_writedata[3:0];
            if (reg_sel(avs_address, REG_INDEX_IDX)) begin
                if (avs_byteenable[1])
                    next_expected_index = avs_writedata[IDX_EXP_LSB +: 4];
                if (avs_byteenable[0])
                    next_received_index = avs_writedata[IDX_RX_LSB +: 4];
            end
            if (reg_sel(avs_address, REG_IRQ_EN_IDX)) begin
                if (avs_byteenable[0])
                    next_irq_enable = avs_writedata[3:0];
                if (avs_byteenable[1])
                    next_global_irq_enable = avs_writedata[IRQ_GLOBAL_BIT];
            end
            if (reg_sel(avs_address, REG_LATCH_CLR_IDX) && avs_byteenable[0])
                latch_clear = avs_writedata[3:0];
            if (reg_sel(avs_address, REG_EXP_ID_IDX) && avs_byteenable[0])
                next_exp_id[{expected_index, 3'b000} +: 8] = avs_writedata[7:0];
        end
        // Any read or write of the expected byte steps the pointer; 4-bit add wraps Fh to 0h
        if (commit && reg_sel(avs_address, REG_EXP_ID_IDX))
            next_expected_index = expected_index + 4'h1;
        if (commit && avs_read && reg_sel(avs_address, REG_RX_ID_IDX))
            next_received_index = received_index + 4'h1;
        next_waitrequest = (next_bus_state != TRTR_BUS_ACK);
    end

    // Register stage for the bus and software state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_state         <= TRTR_BUS_WAIT;
            avs_readdata      <= 32'h0000_0000;
            avs_waitrequest   <= 1'b1;
            control           <= CONTROL_RESET;
            expected_index    <= INDEX_RESET;
            received_index    <= INDEX_RESET;
            irq_enable        <= STATUS_RESET;
            global_irq_enable <= 1'b0;
            exp_id            <= ID_RESET;
        end else begin
            bus_state         <= next_bus_state;
            avs_readdata      <= next_readdata;
            avs_waitrequest   <= next_waitrequest;
            control           <= next_control;
            expected_index    <= next_expected_index;
            received_index    <= next_received_index;
            irq_enable        <= next_irq_enable;
            global_irq_enable <= next_global_irq_enable;
            exp_id            <= next_exp_id;
        end
    end

    // ------------------------------------------------------------------
    // Identifier capture, acceptance and status
    // ------------------------------------------------------------------
    // A set first bit marks byte zero of the multiframe; unaligned capture starts anywhere
    always_comb begin
        cmp_active = control[CTL_CMP_EN_BIT] && !control[CTL_ALIGN_DIS_BIT];
        pos_wr     = (!control[CTL_ALIGN_DIS_BIT] && rx_byte_first) ? 4'h0 : byte_pos;
        assembled  = cap_id;
        assembled[{pos_wr, 3'b000} +: 8] = rx_byte;
        id_done              = rx_byte_valid && (pos_wr == LAST_BYTE_POS);
        id_change            = 1'b0;
        next_cap_id          = cap_id;
        next_byte_pos        = byte_pos;
        next_cur_id          = cur_id;
        next_rx_id           = rx_id;
        next_unstable_cnt    = unstable_cnt;
        next_idle_cnt        = idle_cnt;
        next_unstable_status = unstable_status;
        next_idle_status     = idle_status;
        if (rx_byte_valid) begin
            next_cap_id   = assembled;
            next_byte_pos = pos_wr + 4'h1;
        end
        if (id_done) begin
            next_cur_id = assembled;
            // Two identical identifiers in a row are taken as the new received identifier
            if (assembled == cur_id && assembled != rx_id) begin
                next_rx_id = assembled;
                id_change  = 1'b1;
            end
            if (assembled != rx_id && assembled != cur_id) begin
                if (unstable_cnt != UNSTABLE_LIMIT)
                    next_unstable_cnt = unstable_cnt + 4'h1;
                next_unstable_status = unstable_status || (next_unstable_cnt == UNSTABLE_LIMIT);
            end else begin
                next_unstable_cnt    = 4'h0;
                next_unstable_status = 1'b0;
            end
            if (assembled == ID_RESET) begin
                if (idle_cnt != IDLE_LIMIT)
                    next_idle_cnt = idle_cnt + 3'h1;
                next_idle_status = (next_idle_cnt == IDLE_LIMIT);
            end else begin
                next_idle_cnt    = 3'h0;
                next_idle_status = 1'b0;
            end
        end
        next_mismatch_status = cmp_active && (rx_id != exp_id);
    end

    // Register stage for the capture path
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cap_id          <= ID_RESET;
            cur_id          <= ID_RESET;
            rx_id           <= ID_RESET;
            byte_pos        <= 4'h0;
            unstable_cnt    <= 4'h0;
            idle_cnt        <= 3'h0;
            mismatch_status <= 1'b0;
            unstable_status <= 1'b0;
            idle_status     <= 1'b0;
        end else begin
            cap_id          <= next_cap_id;
            cur_id          <= next_cur_id;
            rx_id           <= next_rx_id;
            byte_pos        <= next_byte_pos;
            unstable_cnt    <= next_unstable_cnt;
            idle_cnt        <= next_idle_cnt;
            mismatch_status <= next_mismatch_status;
            unstable_status <= next_unstable_status;
            idle_status     <= next_idle_status;
        end
    end

    // ------------------------------------------------------------------
    // Latched status and interrupt
    // ------------------------------------------------------------------
    // A new event beats a clear in the same cycle, so nothing slips past software
    always_comb begin
        next_latched = latched & ~latch_clear;
        next_latched[ST_CHANGE_BIT]   = next_latched[ST_CHANGE_BIT] | id_change;
        next_latched[ST_MISMATCH_BIT] = next_latched[ST_MISMATCH_BIT] | (next_mismatch_status & ~mismatch_status);
        next_latched[ST_UNSTABLE_BIT] = next_latched[ST_UNSTABLE_BIT] | (next_unstable_status & ~unstable_status);
        next_latched[ST_IDLE_BIT]     = next_latched[ST_IDLE_BIT] | (next_idle_status & ~idle_status);
        next_irq = next_global_irq_enable && |(next_latched & next_irq_enable);
    end

    // Register stage for latches and interrupt line
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            latched <= STATUS_RESET;
            irq     <= 1'b0;
        end else begin
            latched <= next_latched;
            irq     <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking rx_cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_align_restart:
        assert property (rx_byte_valid && rx_byte_first && !control[CTL_ALIGN_DIS_BIT] |=> byte_pos == 4'h1)
        else $error("aligned byte did not restart position");
    chk_compare_off:
        assert property (!control[CTL_CMP_EN_BIT] |=> !mismatch_status)
        else $error("mismatch raised with comparison disabled");
    chk_align_blocks_cmp:
        assert property (control[CTL_ALIGN_DIS_BIT] |=> !mismatch_status)
        else $error("mismatch raised while alignment disabled");
    chk_exp_index_step:
        assert property (commit && reg_sel(avs_address, REG_EXP_ID_IDX) |=>
                         expected_index == $past(expected_index) + 4'h1)
        else $error("expected index did not step");
    chk_rx_index_wrap:
        assert property (commit && avs_read && reg_sel(avs_address, REG_RX_ID_IDX) && received_index == 4'hf
                         |=> received_index == 4'h0)
        else $error("received index did not wrap");
    chk_mismatch_value:
        assert property (cmp_active && rx_id != exp_id ##1 cmp_active && rx_id != exp_id |-> mismatch_status)
        else $error("mismatch not declared for differing identifiers");
    chk_unstable_set:
        assert property (id_done && assembled != rx_id && assembled != cur_id && unstable_cnt == 4'h7
                         |=> unstable_status)
        else $error("unstable not declared after eight");
    chk_idle_set:
        assert property (id_done && assembled == ID_RESET && idle_cnt == 3'h4 |=> idle_status)
        else $error("idle not declared after five");
    chk_latch_rise:
        assert property ($rose(mismatch_status) |-> latched[ST_MISMATCH_BIT])
        else $error("mismatch rise not latched");
    chk_irq_gate:
        assert property (irq |-> global_irq_enable && |(latched & irq_enable))
        else $error("interrupt without enabled latched bit");
    chk_read_data:
        assert property (bus_state == TRTR_BUS_WAIT && avs_read && reg_sel(avs_address, REG_RX_ID_IDX)
                         |=> avs_readdata[7:0] == $past(rx_id[{received_index, 3'b000} +: 8]))
        else $error("received byte read wrong");

    cov_unstable: cover property ($rose(unstable_status));
    cov_idle:     cover property ($rose(idle_status));
    cov_change:   cover property (id_change);
    cov_irq:      cover property ($rose(irq));

endmodule : trtr_receiver

// ==== hw/trtr_pkg.sv ====
// Constants shared by the trail trace receiver: register indices, field positions, reset values, run lengths
package trtr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address on the bus is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CONTROL_IDX   = 8'hf0;
    localparam logic [7:0] REG_INDEX_IDX     = 8'hf2;
    localparam logic [7:0] REG_STATUS_IDX    = 8'hf4;
    localparam logic [7:0] REG_LATCHED_IDX   = 8'hf6;
    localparam logic [7:0] REG_IRQ_EN_IDX    = 8'hf8;
    localparam logic [7:0] REG_LATCH_CLR_IDX = 8'hfa;
    localparam logic [7:0] REG_RX_ID_IDX     = 8'hfc;
    localparam logic [7:0] REG_EXP_ID_IDX    = 8'hfe;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_ALIGN_DIS_BIT = 3;
    localparam int CTL_CMP_EN_BIT    = 2;
    localparam int CTL_INVERT_BIT    = 1;
    localparam int CTL_REORDER_BIT   = 0;
    localparam int IDX_EXP_LSB       = 8;
    localparam int IDX_RX_LSB        = 0;
    localparam int ST_CHANGE_BIT     = 3;
    localparam int ST_MISMATCH_BIT   = 2;
    localparam int ST_UNSTABLE_BIT   = 1;
    localparam int ST_IDLE_BIT       = 0;
    localparam int IRQ_GLOBAL_BIT    = 15;

    // ------------------------------------------------------------------
    // Reset values and run lengths
    // ------------------------------------------------------------------
    localparam logic [3:0]  CONTROL_RESET  = 4'h0;
    localparam logic [3:0]  INDEX_RESET    = 4'h0;
    localparam logic [3:0]  STATUS_RESET   = 4'h0;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [127:0] ID_RESET      = 128'h0;
    localparam logic [3:0]  LAST_BYTE_POS  = 4'hf;
    localparam logic [3:0]  UNSTABLE_RUN   = 4'h8;
    localparam logic [2:0]  IDLE_RUN       = 3'h5;

    // Bus handshake: one wait cycle, then the acknowledge cycle
    typedef enum logic [0:0] {
        TRTR_BUS_WAIT = 1'b0,
        TRTR_BUS_ACK  = 1'b1
    } trtr_bus_state_t;

endpackage : trtr_pkg

// ==== hw/trtr_bit_deser.sv ====
// Bit deserialiser for incoming trace bits with optional inversion and bit reordering
`timescale 1ns/100ps

module trtr_bit_deser (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       trace_bit,
    input  wire logic       trace_bit_valid,
    input  wire logic       trace_byte_start,
    input  wire logic       rx_invert_enable,
    input  wire logic       rx_bit_reorder_enable,
    output logic      [7:0] byte_data,
    output logic            byte_first_bit,
    output logic            byte_valid
);
    import trtr_pkg::*;

    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic       first_bit;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_shreg;
    logic       next_first_bit;
    logic [7:0] next_byte_data;
    logic       next_byte_first_bit;
    logic       next_byte_valid;
    logic       line_bit;

    // ------------------------------------------------------------------
    // Shift and byte assembly
    // ------------------------------------------------------------------
    // Byte start restarts the count, so a slip in the framer heals in one byte
    always_comb begin
        line_bit            = trace_bit ^ rx_invert_enable;
        next_bit_cnt        = bit_cnt;
        next_shreg          = shreg;
        next_first_bit      = first_bit;
        next_byte_data      = byte_data;
        next_byte_first_bit = byte_first_bit;
        next_byte_valid     = 1'b0;
        if (trace_bit_valid) begin
            if (trace_byte_start) begin
                next_shreg     = rx_bit_reorder_enable ? {line_bit, 7'h00} : {7'h00, line_bit};
                next_first_bit = line_bit;
                next_bit_cnt   = 3'h1;
            end else begin
                next_shreg   = rx_bit_reorder_enable ? {line_bit, shreg[7:1]} : {shreg[6:0], line_bit};
                next_bit_cnt = bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    next_byte_data      = next_shreg;
                    next_byte_first_bit = first_bit;
                    next_byte_valid     = 1'b1;
                end
            end
        end
    end

    // Register stage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bit_cnt        <= 3'h0;
            shreg          <= BYTE_RESET;
            first_bit      <= 1'b0;
            byte_data      <= BYTE_RESET;
            byte_first_bit <= 1'b0;
            byte_valid     <= 1'b0;
        end else begin
            bit_cnt        <= next_bit_cnt;
            shreg          <= next_shreg;
            first_bit      <= next_first_bit;
            byte_data      <= next_byte_data;
            byte_first_bit <= next_byte_first_bit;
            byte_valid     <= next_byte_valid;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking deser_cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_invert_first:
        assert property (trace_bit_valid && trace_byte_start |=> first_bit == $past(trace_bit ^ rx_invert_enable))
        else $error("first trace bit not inverted as configured");
    chk_first_bit_place:
        assert property (byte_valid && $stable(rx_bit_reorder_enable) |->
                         byte_data[rx_bit_reorder_enable ? 0 : 7] == byte_first_bit)
        else $error("first received bit in wrong byte position");

endmodule : trtr_bit_deser

// ==== testbench/trtr_far_end.sv ====
// Far-end model: framer overhead extraction feeding serial trace bits
`timescale 1ns/100ps

module trtr_far_end (
    input  wire logic ref_clk,
    output logic      trace_bit,
    output logic      trace_bit_valid,
    output logic      trace_byte_start
);
    // ------------------------------------------------------------------
    // Serial trace source
    // ------------------------------------------------------------------
    initial begin
        {trace_bit, trace_bit_valid, trace_byte_start} = 3'h0;
    end

    // One identifier, bytes back to back, wire order and polarity per mode
    task automatic send_id(input logic [15:0][7:0] v, input logic inv, input logic reo);
        for (int k = 0; k < 16; k++) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge ref_clk);
                trace_bit <= (reo ? v[k][i] : v[k][7-i]) ^ inv;
                {trace_bit_valid, trace_byte_start} <= {1'b1, i == 0};
            end
        end
        @(posedge ref_clk);
        {trace_bit_valid, trace_byte_start} <= 2'h0;
        trace_bit <= ~trace_bit; // Stale bit never looks like data
    endtask : send_id
endmodule : trtr_far_end

// ==== testbench/test_trtr_receiver.sv ====
// Self-checking bench for the trail trace receiver
`timescale 1ns/100ps

module test_trtr_receiver;
    logic             ref_clk, srst, avs_read, avs_write, avs_waitrequest, irq;
    logic             trace_bit, trace_bit_valid, trace_byte_start;
    logic [9:0]       avs_address;
    logic [31:0]      avs_writedata, avs_readdata;
    logic [15:0]      q;
    logic [15:0][7:0] ex, id, rot;
    int               miscompares = 0;
    int               check_count = 0;

    trtr_far_end u_far (.ref_clk, .trace_bit, .trace_bit_valid, .trace_byte_start);
    trtr_receiver u_dut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .trace_bit, .trace_bit_valid,
        .trace_byte_start, .irq);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // Avalon-MM cycle: hold until waitrequest sampled low, bounded wait
    task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, 16'h0, d};
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata[15:0];
        {avs_read, avs_write} <= 2'b00;
        if (n == 50) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : bus

    task automatic rd(input logic [9:0] a, input string s, input logic [15:0] e);
        bus(1'b0, a, 16'h0);
        chk(s, e, q);
    endtask : rd

    task automatic irqchk(input logic e);
        repeat (3) @(posedge ref_clk);
        chk("irq", {15'h0, e}, {15'h0, irq});
    endtask : irqchk

    task automatic send(input logic [15:0][7:0] v, input int n, input logic [1:0] m);
        repeat (n) u_far.send_id(v, m[1], m[0]);
        repeat (4) @(posedge ref_clk); // Status settles after the last byte
    endtask : send

    // Random identifier: only byte 0 carries the alignment marker in both orders
    function automatic logic [15:0][7:0] rid();
        logic [15:0][7:0] v;
        foreach (v[k]) v[k] = 8'($urandom) & 8'h7e;
        v[0] = v[0] | 8'h81;
        return v;
    endfunction : rid

    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        {srst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 10'h0, 32'h0};
        void'($urandom(32'h9d797548));
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rd(10'h3c0, "control", 16'h0000);
        rd(10'h3c8, "index", 16'h0000);
        rd(10'h3b0, "unmapped", 16'h0000);
        bus(1'b1, 10'h3c0, 16'h0004);
        bus(1'b1, 10'h3e0, 16'h8004);
        ex = rid();
        for (int k = 0; k < 16; k++) bus(1'b1, 10'h3f8, ex[k]);
        rd(10'h3c8, "index", 16'h0000);
        for (int k = 0; k < 16; k++) rd(10'h3f8, "exp_byte", ex[k]);
        bus(1'b1, 10'h3c8, 16'h0f00);
        rd(10'h3f8, "exp_byte", ex[15]);
        rd(10'h3c8, "index", 16'h0000);
        for (int m = 0; m < 4; m++) begin
            id = rid();
            // Start five bytes in, so only the marker can put byte zero back in place
            foreach (rot[k]) rot[k] = id[(k + 5) % 16];
            bus(1'b1, 10'h3c0, 16'h0004 | 16'(m));
            send(rot, 3, 2'(m));
            for (int k = 0; k < 16; k++) rd(10'h3f0, "rx_byte", id[k]);
            rd(10'h3c8, "rx_index", 16'h0000);
            rd(10'h3d0, "status", {13'h0, id != ex, 2'b00});
        end
        rd(10'h3d8, "latched", 16'h000c);
        irqchk(1'b1);
        bus(1'b1, 10'h3e0, 16'h0004);
        irqchk(1'b0);
        bus(1'b1, 10'h3e0, 16'h8004);
        bus(1'b1, 10'h3e8, 16'h000f);
        rd(10'h3d8, "latched", 16'h0000);
        irqchk(1'b0);
        bus(1'b1, 10'h3c0, 16'h0004);
        send(ex, 2, 2'b00);
        rd(10'h3d0, "status", 16'h0000);
        repeat (8) send(rid(), 1, 2'b00);
        rd(10'h3d0, "status", 16'h0002);
        send(ex, 1, 2'b00);
        rd(10'h3d0, "status", 16'h0000);
        bus(1'b1, 10'h3c0, 16'h0000);
        send(rid(), 2, 2'b00);
        rd(10'h3d0, "status", 16'h0000);
        bus(1'b1, 10'h3c0, 16'h000c);
        for (int i = 0; i < 5; i++) begin
            send('0, 1, 2'b00);
            if (i >= 3) rd(10'h3d0, "status", {15'h0, i == 4});
        end
        tally_and_finish();
    end
endmodule : test_trtr_receiver
